/* File: hdl/ske_pkg.sv */
// Shared constants and types for the two-wire serial EEPROM slave.
// Assumes a single 125 MHz core clock; the serial clock is a separate domain.
package ske_pkg;

  // ********************************************************
  // Array geometry
  // ********************************************************
  localparam int         ADDR_W      = 10;
  localparam int         PAGE_W      = 4;
  localparam int         PAGE_BYTES  = 16;
  localparam int         DEPTH       = 1024;

  // ********************************************************
  // Device address word fields
  // ********************************************************
  localparam logic [3:0] DEV_PREFIX  = 4'hA;
  localparam int         DEV_PFX_LSB = 4;
  localparam int         DEV_CS_BIT  = 3;
  localparam int         DEV_RW_BIT  = 0;
  localparam int         ADDR_HI_W   = 2;

  // ********************************************************
  // Bit slot counter
  // ********************************************************
  localparam int         BIT_CNT_W   = 4;
  localparam logic [3:0] BIT_FIRST   = 4'h0;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] BIT_ACK     = 4'h8;

  // ********************************************************
  // Write cycle time
  // ********************************************************
  localparam int         CLK_KHZ     = 125000;
  localparam int         TWR_MS      = 5;
  localparam int         WR_CYCLES   = TWR_MS * CLK_KHZ;
  localparam int         WR_CNT_W    = 20;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic       SDA_LOW     = 1'b0;
  localparam logic       STANDBY_RST = 1'b1;
  localparam logic [5:0] PINS_IDLE   = 6'h30;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE
  } ske_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic cs_high;
    logic cs_mid;
    logic cs_low;
  } ske_pins_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } ske_evt_type;

endpackage : ske_pkg

/* File: hdl/ske_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a level that stays put for many clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ske_sync
  import ske_pkg::*;
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (ce) begin
      nxt_meta = din;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule : ske_sync
`default_nettype wire

/* File: hdl/ske_wr_timer.sv */
// Self-timed programming cycle counter.
// Assumes start is a single-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ske_wr_timer
  import ske_pkg::*;
#(
  parameter int CYCLES = WR_CYCLES
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Cycle control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam logic [WR_CNT_W-1:0] LAST = WR_CNT_W'(CYCLES - 1);

  logic [WR_CNT_W-1:0] cnt_ff;
  logic [WR_CNT_W-1:0] nxt_cnt;
  logic                busy_ff;
  logic                nxt_busy;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (ce) begin
      if (busy_ff) begin
        if (cnt_ff == LAST) begin
          nxt_busy = 1'b0;
          nxt_cnt  = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end else if (start) begin
        nxt_busy = 1'b1;
        nxt_cnt  = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff && ce && (cnt_ff == LAST);

  wr_time_bound_a: assert property (@(posedge clk) disable iff (rst)
    done |=> !busy_ff && cnt_ff == '0)
    else $error("write cycle did not end at its terminal count");

endmodule : ske_wr_timer
`default_nettype wire

/* File: hdl/ske_eeprom_slave.sv */
// Two-wire serial EEPROM slave: framing, addressing, acknowledge, page write.
// Assumes an open-drain wire resolved outside; scl is the link clock port.
//
// Functional notes
// - Bits are captured on serial clock rise and shifted out after its fall.
// - A floating select input is treated as low in the address compare.
// - The data line is only pulled low or released, never driven high.
// - Write protect high blocks all programming; low or open allows it.
// - Reads behave the same whatever the write protect level.
// - Array is 64 pages of 16 bytes, reached by a 10-bit word address.
// - Data changes only while the serial clock is low, except START/STOP.
// - Data falling while clock high is START; every command begins with one.
// - Data rising while clock high is STOP; every command ends with one.
// - STOP after read gives standby at once; after write, once programmed.
// - Each received byte is acknowledged low during the ninth clock.
// - Standby after power-up, after a read STOP, and after programming.
// - Device word follows START; only prefix 1010 is accepted.
// - Acknowledge device word only on select match; else ignore until next START.
// - Only the fifth address bit is compared, against the single select pin.
// - Eighth device bit high selects read, low selects write.
// - Byte write: two word address bytes then one data byte, each acknowledged.
// - After write STOP, the timed cycle runs and all inputs are ignored.
// - Page write: up to 15 more bytes after the first, each acknowledged.
// - Page write advances only the in-page address bits and wraps.
// - No acknowledge of the device word while programming; normal afterwards.
// - Programming ends within the write cycle time; partial pages allowed.
// - Address counter holds last address plus one; reads advance and wrap.
// - A START after the word address, before data, abandons the write.
`timescale 1ns/1ps
`default_nettype none
module ske_eeprom_slave
  import ske_pkg::*;
#(
  parameter int WR_CYCLES_P = WR_CYCLES
) (
  // Core clock and control
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Two-wire link
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Protect and select pins
  input  wire logic wp,
  input  wire logic chip_select_pin_high,
  input  wire logic unused_select_pin_mid,
  input  wire logic unused_select_pin_low,
  // Status
  output logic      standby,
  output logic      write_busy
);

  // ********************************************************
  // Declarations
  // ********************************************************
  ske_pins_type           pins_raw;
  ske_pins_type           pins_s;
  ske_pins_type           pins_q_ff;
  ske_evt_type            evt;
  ske_state_type          state_ff;
  ske_state_type          nxt_state;
  logic [BIT_CNT_W-1:0]   bit_cnt_ff;
  logic [BIT_CNT_W-1:0]   nxt_bit_cnt;
  logic [ADDR_W-1:0]      addr_ff;
  logic [ADDR_W-1:0]      nxt_addr;
  logic [ADDR_W-PAGE_W-1:0] prog_page_ff;
  logic [ADDR_W-PAGE_W-1:0] nxt_prog_page;
  logic [7:0]             page_buf_ff [PAGE_BYTES];
  logic [7:0]             nxt_page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]  page_mask_ff;
  logic [PAGE_BYTES-1:0]  nxt_page_mask;
  logic                   wr_pend_ff;
  logic                   nxt_wr_pend;
  logic                   ack_ff;
  logic                   nxt_ack;
  logic                   sda_oe_ff;
  logic                   nxt_sda_oe;
  logic                   sda_o_ff;
  logic                   standby_ff;
  logic                   nxt_standby;
  logic                   wr_busy_ff;
  logic                   nxt_wr_busy;
  logic                   start_prog;
  logic                   prog_busy;
  logic                   prog_done;
  logic [7:0]             rx_shift_ff;
  logic [7:0]             nxt_rx_shift;
  logic [7:0]             rx_word;
  logic [7:0]             rd_byte;
  logic [2:0]             tx_idx;
  logic [7:0]             mem [DEPTH];

  // Prefix and select compare; select pin assumed pulled low when open
  function automatic logic dev_match(input logic [7:0] word, input logic cs_pin);
    dev_match = (word[7:DEV_PFX_LSB] == DEV_PREFIX)
             && (word[DEV_CS_BIT] == cs_pin);
  endfunction : dev_match

  // ********************************************************
  // Link domain: serial capture
  // ********************************************************
  // The shift register runs on the serial clock itself. The core reads it
  // only after the synchronised rise of the eighth bit, when it cannot
  // change again until the next real rising edge, microseconds away.
  always_comb begin
    nxt_rx_shift = {rx_shift_ff[6:0], sda_i};
  end

  always_ff @(posedge scl) begin
    rx_shift_ff <= nxt_rx_shift;
  end

  assign rx_word = rx_shift_ff;

  // ********************************************************
  // Pin synchronisers and bus events
  // ********************************************************
  always_comb begin
    pins_raw.scl     = scl;
    pins_raw.sda     = sda_i;
    pins_raw.wp      = wp;
    pins_raw.cs_high = chip_select_pin_high;
    pins_raw.cs_mid  = unused_select_pin_mid;
    pins_raw.cs_low  = unused_select_pin_low;
  end

  ske_sync #(
    .WIDTH ($bits(ske_pins_type)),
    .INIT  (PINS_IDLE)
  ) u_pin_sync (
    .clk  (core_clk),
    .rst  (sys_rst),
    .ce   (clk_en),
    .din  (pins_raw),
    .dout (pins_s)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pins_q_ff <= PINS_IDLE;
    end else if (clk_en) begin
      pins_q_ff <= pins_s;
    end
  end

  always_comb begin
    evt.rise  = clk_en && pins_s.scl && !pins_q_ff.scl;
    evt.fall  = clk_en && !pins_s.scl && pins_q_ff.scl;
    evt.start = clk_en && pins_s.scl && pins_q_ff.scl
             && pins_q_ff.sda && !pins_s.sda;
    evt.stop  = clk_en && pins_s.scl && pins_q_ff.scl
             && !pins_q_ff.sda && pins_s.sda;
  end

  // ********************************************************
  // Programming cycle
  // ********************************************************
  ske_wr_timer #(
    .CYCLES (WR_CYCLES_P)
  ) u_wr_timer (
    .clk   (core_clk),
    .rst   (sys_rst),
    .ce    (clk_en),
    .start (start_prog),
    .busy  (prog_busy),
    .done  (prog_done)
  );

  // Only bytes actually received are programmed, so partial pages work
  always_ff @(posedge core_clk) begin
    if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask_ff[i]) begin
          mem[{prog_page_ff, PAGE_W'(i)}] <= page_buf_ff[i];
        end
      end
    end
  end

  // Read path never looks at the protect pin
  assign rd_byte = mem[addr_ff];
  assign tx_idx  = 3'(BIT_LAST - bit_cnt_ff);

  // ********************************************************
  // Protocol engine
  // ********************************************************
  always_comb begin
    nxt_state     = state_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_addr      = addr_ff;
    nxt_prog_page = prog_page_ff;
    nxt_page_buf  = page_buf_ff;
    nxt_page_mask = page_mask_ff;
    nxt_wr_pend   = wr_pend_ff;
    nxt_ack       = ack_ff;
    nxt_sda_oe    = sda_oe_ff;
    start_prog    = 1'b0;
    if (evt.start) begin
      nxt_state   = ST_DEV;
      nxt_bit_cnt = BIT_FIRST;
      nxt_ack     = 1'b0;
      nxt_sda_oe  = 1'b0;
      nxt_wr_pend = 1'b0;
      // A pending page is dropped, but not one being programmed
      if (!prog_busy) begin
        nxt_page_mask = '0;
      end
    end else if (evt.stop) begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_ack    = 1'b0;
      nxt_wr_pend = 1'b0;
      if (state_ff == ST_WDATA && wr_pend_ff && !pins_s.wp) begin
        start_prog    = 1'b1;
        nxt_prog_page = addr_ff[ADDR_W-1:PAGE_W];
      end
    end else begin
      if (evt.rise) begin
        nxt_bit_cnt = (bit_cnt_ff == BIT_ACK) ? BIT_FIRST : bit_cnt_ff + 1'b1;
        if (bit_cnt_ff == BIT_LAST) begin
          case (state_ff)
            ST_DEV: begin
              if (dev_match(rx_word, pins_s.cs_high) && !prog_busy) begin
                nxt_ack   = 1'b1;
                nxt_state = rx_word[DEV_RW_BIT] ? ST_RDATA : ST_ADDR_HI;
              end else begin
                nxt_state = ST_IGNORE;
              end
            end
            ST_ADDR_HI: begin
              nxt_addr[ADDR_W-1:ADDR_W-ADDR_HI_W] = rx_word[ADDR_HI_W-1:0];
              nxt_ack   = 1'b1;
              nxt_state = ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              nxt_addr[7:0] = rx_word;
              nxt_ack   = 1'b1;
              nxt_state = ST_WDATA;
            end
            ST_WDATA: begin
              nxt_page_buf[addr_ff[PAGE_W-1:0]]  = rx_word;
              nxt_page_mask[addr_ff[PAGE_W-1:0]] = 1'b1;
              nxt_addr[PAGE_W-1:0] = addr_ff[PAGE_W-1:0] + 1'b1;
              nxt_wr_pend = 1'b1;
              nxt_ack     = 1'b1;
            end
            ST_RDATA: begin
              nxt_addr = addr_ff + 1'b1;
            end
            default: begin
            end
          endcase
        end else if (bit_cnt_ff == BIT_ACK && state_ff == ST_RDATA && pins_s.sda) begin
          // Master did not acknowledge: stay off the line until STOP
          nxt_state = ST_IGNORE;
        end
      end
      if (evt.fall) begin
        if (bit_cnt_ff == BIT_ACK) begin
          nxt_sda_oe = ack_ff;
          nxt_ack    = 1'b0;
        end else if (state_ff == ST_RDATA) begin
          nxt_sda_oe = !rd_byte[tx_idx];
        end else begin
          nxt_sda_oe = 1'b0;
        end
      end
    end
    nxt_wr_busy = start_prog || (prog_busy && !prog_done);
    nxt_standby = (nxt_state == ST_IDLE) && !nxt_wr_busy;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= BIT_FIRST;
      addr_ff      <= '0;
      prog_page_ff <= '0;
      page_mask_ff <= '0;
      wr_pend_ff   <= 1'b0;
      ack_ff       <= 1'b0;
      sda_oe_ff    <= 1'b0;
      sda_o_ff     <= SDA_LOW;
      standby_ff   <= STANDBY_RST;
      wr_busy_ff   <= 1'b0;
    end else if (clk_en) begin
      state_ff     <= nxt_state;
      bit_cnt_ff   <= nxt_bit_cnt;
      addr_ff      <= nxt_addr;
      prog_page_ff <= nxt_prog_page;
      page_mask_ff <= nxt_page_mask;
      wr_pend_ff   <= nxt_wr_pend;
      ack_ff       <= nxt_ack;
      sda_oe_ff    <= nxt_sda_oe;
      sda_o_ff     <= SDA_LOW;
      standby_ff   <= nxt_standby;
      wr_busy_ff   <= nxt_wr_busy;
    end
  end

  // Page buffer is data only; its contents matter only where masked
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      page_buf_ff <= nxt_page_buf;
    end
  end

  assign sda_o      = sda_o_ff;
  assign sda_oe     = sda_oe_ff;
  assign standby    = standby_ff;
  assign write_busy = wr_busy_ff;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence word_done_s;
    evt.rise && bit_cnt_ff == BIT_LAST;
  endsequence

  sequence ack_slot_s;
    evt.fall && bit_cnt_ff == BIT_ACK;
  endsequence

  sequence dev_word_s;
    word_done_s and state_ff == ST_DEV;
  endsequence

  sda_low_change_a: assert property (
    $changed(sda_oe_ff) |-> !$past(pins_s.scl))
    else $error("data line drive changed while clock high");

  open_drain_a: assert property (
    sda_oe_ff |-> sda_o == 1'b0)
    else $error("data line driven high");

  ninth_ack_a: assert property (
    ack_ff ##0 ack_slot_s |=> sda_oe_ff ##1 !ack_ff)
    else $error("acknowledge not driven in ninth clock");

  dev_mismatch_a: assert property (
    dev_word_s ##0 !dev_match(rx_word, pins_s.cs_high) |=> state_ff == ST_IGNORE && !ack_ff)
    else $error("mismatched device word was accepted");

  poll_nack_a: assert property (
    dev_word_s ##0 prog_busy |=> !ack_ff)
    else $error("device word acknowledged while programming");

  dir_select_a: assert property (
    dev_word_s ##0 dev_match(rx_word, pins_s.cs_high) ##0 !prog_busy
      |=> (state_ff == ST_RDATA) == $past(rx_word[DEV_RW_BIT]))
    else $error("direction bit not honoured");

  page_wrap_a: assert property (
    word_done_s ##0 state_ff == ST_WDATA
      |=> addr_ff[ADDR_W-1:PAGE_W] == $past(addr_ff[ADDR_W-1:PAGE_W])
       && addr_ff[PAGE_W-1:0] == PAGE_W'($past(addr_ff[PAGE_W-1:0]) + 1'b1))
    else $error("page write address left its page");

  read_advance_a: assert property (
    word_done_s ##0 state_ff == ST_RDATA |=> addr_ff == ADDR_W'($past(addr_ff) + 1'b1))
    else $error("read did not advance the address counter");

  wp_inhibit_a: assert property (
    $rose(prog_busy) |-> $past(evt.stop) && !$past(pins_s.wp))
    else $error("programming started without an unprotected STOP");

  read_standby_a: assert property (
    evt.stop && state_ff inside {ST_RDATA, ST_IGNORE} && !prog_busy |=> standby_ff)
    else $error("no standby right after read STOP");

  abandon_write_a: assert property (
    evt.start && !prog_busy |=> page_mask_ff == '0 && state_ff == ST_DEV)
    else $error("START did not abandon the pending write");

endmodule : ske_eeprom_slave
`default_nettype wire

/* File: tb/ske_mst_model.sv */
// Two-wire bus master model: drives the serial clock and pulls the data wire.
// Assumes the bench resolves the open-drain wire with a pull-up and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module ske_mst_model (
  // Link
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Phases well above the synchroniser latency of the core domain
  localparam int Q = 80;
  localparam int H = 320;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ********************************************************
  // Bit and frame primitives
  // ********************************************************
  task automatic bit_put(input logic b);
    #(Q) sda_low = !b;
    #(H-Q) scl = 1'b1;
    #(H) scl = 1'b0;
  endtask : bit_put

  task automatic bit_get(output logic b);
    #(Q) sda_low = 1'b0;
    #(H-Q) scl = 1'b1;
    #(H/2) b = sda;
    #(H/2) scl = 1'b0;
  endtask : bit_get

  // Clock stands high between frames
  task automatic start;
    #(Q) sda_low = 1'b0;
    #(H-Q) scl = 1'b1;
    #(H) sda_low = 1'b1;
    #(H) scl = 1'b0;
  endtask : start

  task automatic stop;
    #(Q) sda_low = 1'b1;
    #(H-Q) scl = 1'b1;
    #(H) sda_low = 1'b0;
    #(H);
  endtask : stop

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_put(b[i]);
    end
    bit_get(ack);
    ack = !ack;
  endtask : put_byte

  task automatic get_byte(input logic more, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_get(v);
      b[i] = v;
    end
    bit_put(!more);
  endtask : get_byte
endmodule : ske_mst_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the two-wire EEPROM slave.
// Assumes the master model in ske_mst_model and a pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ske_pkg::*;
  localparam int WRC   = 2000;
  localparam int LIMIT = 80000;

  logic       core_clk;
  logic       sys_rst;
  logic       clk_en;
  logic       wp;
  logic       cs_hi;
  logic       cs_mid;
  logic       cs_lo;
  wire logic  scl;
  wire logic  m_low;
  wire logic  sda;
  logic       sda_o;
  logic       sda_oe;
  logic       standby;
  logic       write_busy;
  int         err_count;
  int         checks_done;
  int         cyc = 0;
  logic       ack;
  logic [7:0] rd;

  assign sda = !((sda_oe && !sda_o) || m_low);

  ske_eeprom_slave #(.WR_CYCLES_P(WRC)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .chip_select_pin_high(cs_hi),
    .unused_select_pin_mid(cs_mid), .unused_select_pin_low(cs_lo),
    .standby(standby), .write_busy(write_busy));

  ske_mst_model mst (.scl(scl), .sda_low(m_low), .sda(sda));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic conclude;
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] b, input logic exp_ack);
    mst.put_byte(b, ack);
    check(ack, exp_ack);
  endtask : send

  // Device word 0xA6: select bit 0, ignored bits 2:1 set
  task automatic addr_set(input logic [9:0] a);
    mst.start();
    send(8'hA6, 1'b1);
    send({6'h3F, a[9:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask : addr_set

  task automatic read_from(input logic [9:0] a);
    addr_set(a);
    mst.start();
    send(8'hA7, 1'b1);
  endtask : read_from

  task automatic wait_done;
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < WRC + 50) begin
      @(negedge core_clk);
      n++;
    end
    check(write_busy, 1'b0);
    check(standby, 1'b1);
  endtask : wait_done

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset;
    check(sda_oe, 1'b0);
    check(standby, 1'b1);
    check(write_busy, 1'b0);
  endtask : t_reset

  task automatic t_select;
    @(negedge core_clk);
    cs_hi  <= 1'b1;
    cs_mid <= 1'b1;
    cs_lo  <= 1'b1;
    mst.start();
    send(8'hA0, 1'b0);
    mst.stop();
    mst.start();
    send(8'hBE, 1'b0);
    mst.stop();
    mst.start();
    send(8'hA8, 1'b1);
    mst.stop();
    repeat (4) @(negedge core_clk);
    check(write_busy, 1'b0);
    cs_hi  <= 1'b0;
    cs_mid <= 1'b0;
    cs_lo  <= 1'b0;
  endtask : t_select

  task automatic t_byte_write;
    addr_set(10'h000);
    send(8'h5A, 1'b1);
    mst.stop();
    repeat (4) @(negedge core_clk);
    check(write_busy, 1'b1);
    check(standby, 1'b0);
    check(sda_o, 1'b0);
    // Clock enable low must hold the programming timer where it is
    clk_en <= 1'b0;
    repeat (WRC + 10) @(negedge core_clk);
    check(write_busy, 1'b1);
    clk_en <= 1'b1;
    mst.start();
    send(8'hA6, 1'b0);
    mst.stop();
    wait_done();
    mst.start();
    send(8'hA6, 1'b1);
    mst.stop();
  endtask : t_byte_write

  // Start two bytes below the page end so the third byte wraps and the 17th and 18th overwrite the first two
  task automatic t_page_write;
    addr_set(10'h3FE);
    for (int i = 0; i < 18; i++) begin
      send(8'(i), 1'b1);
    end
    mst.stop();
    repeat (4) @(negedge core_clk);
    check(write_busy, 1'b1);
    wait_done();
  endtask : t_page_write

  task automatic t_seq_read;
    read_from(10'h3F0);
    for (int k = 0; k < 17; k++) begin
      mst.get_byte(k < 16, rd);
      check(rd, (k < 16) ? 8'(k + 2) : 8'h5A);
    end
    check(standby, 1'b0);
    mst.stop();
    check(standby, 1'b1);
  endtask : t_seq_read

  task automatic t_protect;
    @(negedge core_clk);
    wp <= 1'b1;
    addr_set(10'h000);
    send(8'hC3, 1'b1);
    mst.stop();
    repeat (6) @(negedge core_clk);
    check(write_busy, 1'b0);
    read_from(10'h000);
    mst.get_byte(1'b0, rd);
    check(rd, 8'h5A);
    mst.stop();
    wp <= 1'b0;
  endtask : t_protect

  initial begin
    err_count   = 0;
    checks_done = 0;
    clk_en      = 1'b1;
    sys_rst     = 1'b1;
    wp          = 1'b0;
    cs_hi       = 1'b0;
    cs_mid      = 1'b0;
    cs_lo       = 1'b0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge core_clk);
    t_reset();
    t_select();
    t_byte_write();
    t_page_write();
    t_seq_read();
    t_protect();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
